// ### logic/scs_pkg.sv
// Purpose: Shared constants and types for the commutation sequencer
// Assumes: 125 MHz system clock
// Notes: Phase bit 0 is A, bit 1 is B, bit 2 is C
package scs_pkg;

    // System clock rate and charge pump oscillator
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned PUMP_HZ = 300_000;
    // Half pump period in clock cycles, rounded down
    localparam int unsigned PUMP_HALF_CYC = CLK_HZ / (2 * PUMP_HZ);

    // Coast time before active braking, in microseconds
    localparam int unsigned BRAKE_DLY_US = 2000;
    localparam int unsigned BRAKE_DLY_CYC = BRAKE_DLY_US * (CLK_HZ / 1_000_000);

    // Commutation steps per mechanical revolution, and the last of the six drive states
    localparam logic [4:0] STEPS_8POLE = 5'h18;
    localparam logic [4:0] STEPS_4POLE = 5'h0C;
    localparam logic [2:0] LAST_STEP = 3'h5;

    // Reset values
    localparam logic [2:0] STEP_RST = 3'h0;
    localparam logic SPIN_RST = 1'b0;

    // Per drive state: sourcing phase, sinking phase, sensed phase
    localparam logic [2:0] HI_TAB [0:5] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    localparam logic [2:0] LO_TAB [0:5] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
    localparam logic [1:0] SNS_TAB [0:5] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0};

    // Operating modes of the output stage
    typedef enum logic [1:0] {
        MODE_COAST = 2'b00,
        MODE_BRAKE = 2'b01,
        MODE_RUN = 2'b10
    } scs_mode_t;

endpackage : scs_pkg

// ### logic/scs_sync.sv
// Purpose: Three-stage synchroniser for asynchronous pin inputs
// Assumes: Inputs are slow compared with the clock
// Notes: Output follows only when the second and third stages agree
`timescale 1ns/10ps
`default_nettype none
module scs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    logic [W-1:0] agree;

    // Width check
    if (W < 1)
    begin : g_bad_w
        $error("scs_sync: W must be at least 1");
    end

    // Shift chain, first stage feeds only the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a bit once stages two and three hold the same value
    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            out_q <= '0;
        else
            out_q <= (agree & s3_q) | (~agree & out_q);
    end

    assign q = out_q;

endmodule : scs_sync
`default_nettype wire

// ### logic/scs_sequencer.sv
// Purpose: Sensorless three-phase spindle commutation sequencer
// Assumes: Pins are asynchronous; clk is 125 MHz; rst async high
// Notes: Phase bit 0 is A, 1 is B, 2 is C
`timescale 1ns/10ps
`default_nettype none
module scs_sequencer #(
    parameter int CW = 16,
    parameter int unsigned BRAKE_CYC = scs_pkg::BRAKE_DLY_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run_brake,
    input wire logic bemf_cmp,
    input wire logic ext_sync,
    input wire logic fb_ext_sel,
    input wire logic [2:0] phase_dly,
    input wire logic pole4_sel,
    input wire logic linear_mode,
    output logic [2:0] phase_hi,
    output logic [2:0] phase_lo,
    output logic [2:0] phase_lo_reg,
    output logic [1:0] bemf_mux,
    output logic spin_sense,
    output logic rev_tick,
    output logic pump_chg,
    output logic pump_xfr
);

    // Parameter checks
    if (CW < 8 || CW > 31)
    begin : g_bad_cw
        $error("scs_sequencer: CW must be 8 to 31");
    end
    if (BRAKE_CYC < 1)
    begin : g_bad_brk
        $error("scs_sequencer: BRAKE_CYC must be at least 1");
    end

    logic [8:0] pins_s;
    logic run_s, bemf_s, ext_s, fbsel_s, pole4_s, lin_s;
    logic [2:0] dly_s;
    logic bemf_p_q, ext_p_q;
    logic fb_evt, zc_take, commute;
    scs_pkg::scs_mode_t mode_q, mode_d;
    logic [2:0] step_q, step_d;
    logic [31:0] brk_cnt_q;
    logic [CW-1:0] ivl_q, period_q, dly_cnt_q, msk_cnt_q;
    logic [CW-1:0] p16, dly_sub, dly_val, quarter;
    logic pend_q, mask_q, spin_q, seen_q, rev_q;
    logic [4:0] rev_cnt_q, rev_lim;
    logic [2:0] hi_d, lo_d, lreg_d, hi_q, lo_q, lreg_q;
    logic [1:0] sns_q;
    logic [8:0] pump_cnt_q;
    logic pump_ph_q, pump_chg_q, pump_xfr_q;

    // Pin synchronisers
    scs_sync #(.W(9)) u_sync (
        .clk(clk),
        .rst(rst),
        .d({linear_mode, pole4_sel, phase_dly, fb_ext_sel, ext_sync,
            bemf_cmp, run_brake}),
        .q(pins_s)
    );
    assign run_s = pins_s[0];
    assign bemf_s = pins_s[1];
    assign ext_s = pins_s[2];
    assign fbsel_s = pins_s[3];
    assign dly_s = pins_s[6:4];
    assign pole4_s = pins_s[7];
    assign lin_s = pins_s[8];

    // Edge memory for feedback sources
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bemf_p_q <= 1'b0;
            ext_p_q <= 1'b0;
        end
        else
        begin
            bemf_p_q <= bemf_s;
            ext_p_q <= ext_s;
        end
    end

    // Feedback event: comparator change or external rising pulse
    assign fb_evt = fbsel_s ? (ext_s & ~ext_p_q)
                            : (bemf_s ^ bemf_p_q);
    // Crossing taken only when unmasked and no commutation pending
    assign zc_take = (mode_q == scs_pkg::MODE_RUN) && !mask_q
                     && !pend_q && fb_evt;
    assign commute = (mode_q == scs_pkg::MODE_RUN) && pend_q
                     && (dly_cnt_q == '0);

    // Delay is half the last interval less dly/16 of it
    assign p16 = period_q >> 4;
    assign dly_sub = (dly_s[0] ? p16 : '0) + (dly_s[1] ? (p16 << 1) : '0)
                     + (dly_s[2] ? (p16 << 2) : '0);
    assign dly_val = (period_q >> 1) - dly_sub;
    assign quarter = period_q >> 2;

    // Next mode and drive state
    always_comb
    begin
        mode_d = mode_q;
        step_d = step_q;
        case (mode_q)
            scs_pkg::MODE_RUN:
            begin
                if (!run_s)
                    mode_d = scs_pkg::MODE_COAST;
                else if (commute)
                    step_d = (step_q == scs_pkg::LAST_STEP) ? 3'h0
                             : step_q + 3'h1;
            end
            scs_pkg::MODE_COAST:
            begin
                if (run_s)
                    mode_d = scs_pkg::MODE_RUN;
                else if (brk_cnt_q <= 32'h1)
                    mode_d = scs_pkg::MODE_BRAKE;
            end
            scs_pkg::MODE_BRAKE:
            begin
                if (run_s)
                    mode_d = scs_pkg::MODE_RUN;
            end
            default:
                mode_d = scs_pkg::MODE_COAST;
        endcase
    end

    // Mode and step registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_q <= scs_pkg::MODE_COAST;
            step_q <= scs_pkg::STEP_RST;
        end
        else
        begin
            mode_q <= mode_d;
            step_q <= step_d;
        end
    end

    // Brake delay timer, reloaded every cycle in run mode, counted down while coasting
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            brk_cnt_q <= BRAKE_CYC;
        else if (mode_q == scs_pkg::MODE_RUN)
            brk_cnt_q <= BRAKE_CYC;
        else if (mode_q == scs_pkg::MODE_COAST && brk_cnt_q != 32'h0)
            brk_cnt_q <= brk_cnt_q - 32'h1;
    end

    // Interval counter saturates at its maximum
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ivl_q <= '0;
            period_q <= '1;
        end
        else if (commute)
        begin
            ivl_q <= '0;
            period_q <= ivl_q;
        end
        else if (mode_q == scs_pkg::MODE_RUN && ivl_q != '1)
            ivl_q <= ivl_q + 1'b1;
    end

    // Pending commutation and its delay counter
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pend_q <= 1'b0;
            dly_cnt_q <= '0;
        end
        else if (mode_q != scs_pkg::MODE_RUN || commute)
            pend_q <= 1'b0;
        else if (zc_take)
        begin
            pend_q <= 1'b1;
            dly_cnt_q <= dly_val;
        end
        else if (pend_q)
            dly_cnt_q <= dly_cnt_q - 1'b1;
    end

    // Blanking mask: set on crossing, held until quarter count expires
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mask_q <= 1'b0;
            msk_cnt_q <= '0;
        end
        else if (mode_q != scs_pkg::MODE_RUN)
        begin
            mask_q <= 1'b0;
            msk_cnt_q <= '0;
        end
        else if (zc_take)
            mask_q <= 1'b1;
        else if (commute)
        begin
            msk_cnt_q <= quarter;
            if (quarter == '0)
                mask_q <= 1'b0;
        end
        else if (msk_cnt_q != '0)
        begin
            msk_cnt_q <= msk_cnt_q - 1'b1;
            if (msk_cnt_q == 1)
                mask_q <= 1'b0;
        end
    end

    // Spin sense starts low and toggles on each crossing
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            spin_q <= scs_pkg::SPIN_RST;
            seen_q <= 1'b0;
        end
        else if (zc_take)
        begin
            spin_q <= ~spin_q;
            seen_q <= 1'b1;
        end
    end

    // Revolution counter, one pulse per mechanical turn
    assign rev_lim = pole4_s ? scs_pkg::STEPS_4POLE : scs_pkg::STEPS_8POLE;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rev_cnt_q <= 5'h0;
            rev_q <= 1'b0;
        end
        else
        begin
            rev_q <= 1'b0;
            if (commute)
            begin
                if (rev_cnt_q >= rev_lim - 5'h1)
                begin
                    rev_cnt_q <= 5'h0;
                    rev_q <= 1'b1;
                end
                else
                    rev_cnt_q <= rev_cnt_q + 5'h1;
            end
        end
    end

    // Drive pattern from next mode and step
    always_comb
    begin
        hi_d = 3'h0;
        lo_d = 3'h0;
        lreg_d = 3'h0;
        if (mode_d == scs_pkg::MODE_BRAKE)
            lo_d = 3'h7;
        else if (mode_d == scs_pkg::MODE_RUN)
        begin
            hi_d = scs_pkg::HI_TAB[step_d];
            if (lin_s)
                lreg_d = scs_pkg::LO_TAB[step_d];
            else
                lo_d = scs_pkg::LO_TAB[step_d];
        end
    end

    // Output stage registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hi_q <= 3'h0;
            lo_q <= 3'h0;
            lreg_q <= 3'h0;
            sns_q <= scs_pkg::SNS_TAB[scs_pkg::STEP_RST];
        end
        else
        begin
            hi_q <= hi_d;
            lo_q <= lo_d;
            lreg_q <= lreg_d;
            sns_q <= scs_pkg::SNS_TAB[step_d];
        end
    end

    // Charge pump phases with one dead cycle at each swap
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pump_cnt_q <= 9'h0;
            pump_ph_q <= 1'b0;
            pump_chg_q <= 1'b0;
            pump_xfr_q <= 1'b0;
        end
        else
        begin
            if (pump_cnt_q == 9'h0)
            begin
                pump_cnt_q <= 9'(scs_pkg::PUMP_HALF_CYC - 1);
                pump_ph_q <= ~pump_ph_q;
            end
            else
                pump_cnt_q <= pump_cnt_q - 9'h1;
            pump_chg_q <= ~pump_ph_q && (pump_cnt_q != 9'h0);
            pump_xfr_q <= pump_ph_q && (pump_cnt_q != 9'h0);
        end
    end

    assign phase_hi = hi_q;
    assign phase_lo = lo_q;
    assign phase_lo_reg = lreg_q;
    assign bemf_mux = sns_q;
    assign spin_sense = spin_q;
    assign rev_tick = rev_q;
    assign pump_chg = pump_chg_q;
    assign pump_xfr = pump_xfr_q;

    // Checks on the sequencer's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_zc_pend;
        zc_take ##1 pend_q;
    endsequence

    a_mask_on_zc: assert property (s_zc_pend |-> mask_q)
        else $error("mask not set after crossing");
    a_spin_toggle: assert property (
        zc_take |=> spin_q != $past(spin_q))
        else $error("spin sense did not toggle");
    a_spin_low_init: assert property (!seen_q |-> !spin_q)
        else $error("spin sense high before first crossing");
    a_half_delay: assert property (
        zc_take |=> dly_cnt_q == $past(dly_val))
        else $error("commutation delay not loaded");
    a_mask_load: assert property (commute && quarter != '0
        |=> msk_cnt_q == $past(quarter) && mask_q)
        else $error("mask counter not loaded");
    a_step_adv: assert property (commute && run_s |=> step_q ==
        (($past(step_q) == 3'h5) ? 3'h0 : $past(step_q) + 3'h1))
        else $error("drive state did not advance");
    a_coast_stop: assert property (mode_q == scs_pkg::MODE_RUN && !run_s
        |=> hi_q == 3'h0 && lo_q == 3'h0 && lreg_q == 3'h0)
        else $error("drivers not off on stop");
    a_brake_lows: assert property (mode_q == scs_pkg::MODE_BRAKE
        |-> lo_q == 3'h7 && hi_q == 3'h0)
        else $error("brake pattern wrong");
    a_state_one: assert property (mode_q == scs_pkg::MODE_RUN
        && step_q == 3'h0 |-> hi_q == 3'h1 && (lo_q | lreg_q) == 3'h2
        && bemf_mux == 2'h2)
        else $error("state one pattern wrong");
    a_state_two: assert property (mode_q == scs_pkg::MODE_RUN
        && step_q == 3'h1 |-> hi_q == 3'h1 && (lo_q | lreg_q) == 3'h4
        && bemf_mux == 2'h1)
        else $error("state two pattern wrong");
    a_no_shoot: assert property ((hi_q & (lo_q | lreg_q)) == 3'h0)
        else $error("phase driven high and low");
    a_pump_excl: assert property (!(pump_chg_q && pump_xfr_q))
        else $error("pump switches both on");

endmodule : scs_sequencer
`default_nettype wire

// ### dv/scs_motor_model.sv
// Purpose: Spindle winding model giving back-EMF crossings
// Assumes: A crossing follows each new drive state after a set wait
// Notes: Noise mode adds a false crossing just after the true one
`timescale 1ns/10ps
`default_nettype none
module scs_motor_model (
    input wire logic clk,
    input wire logic [2:0] phase_hi,
    input wire logic [1:0] bemf_mux,
    input wire logic [7:0] wait_cyc,
    input wire logic noisy,
    input wire logic use_ext,
    output logic bemf_cmp,
    output logic ext_sync
);
    logic [1:0] mux_q = 2'h2;
    logic on_q = 1'b0;
    int cnt = 0;
    int spk = 0;
    initial
    begin
        bemf_cmp = 1'b0;
        ext_sync = 1'b0;
    end
    // Restart the wait on each new or resumed drive state
    always @(posedge clk)
    begin
        #1;
        if (bemf_mux !== mux_q || (phase_hi != 3'h0 && !on_q))
            cnt = wait_cyc;
        else if (cnt > 0)
            cnt = cnt - 1;
        mux_q = bemf_mux;
        on_q = phase_hi != 3'h0;
        // Crossing only while the windings are driven
        if (cnt == 1 && on_q)
        begin
            if (use_ext)
                ext_sync = 1'b1;
            else
                bemf_cmp = ~bemf_cmp;
            spk = 6;
        end
        else if (spk > 0)
            spk = spk - 1;
        // End the sync pulse, add the false crossing
        if (spk == 1)
        begin
            ext_sync = 1'b0;
            if (noisy)
                bemf_cmp = ~bemf_cmp;
        end
    end
endmodule : scs_motor_model
`default_nettype wire

// ### dv/tb_scs_sequencer.sv
// Purpose: Self-checking bench for the commutation sequencer
// Assumes: Short brake and interval counters keep the run brief
// Notes: Stimulus queues expected drive states, a watcher pops them
`timescale 1ns/10ps
`default_nettype none
module tb_scs_sequencer;
    localparam int CW = 8;
    localparam int BRK = 20;
    localparam logic [2:0] HI [0:5] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    localparam logic [2:0] LO [0:5] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
    localparam logic [1:0] SN [0:5] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0};
    logic clk, rst, run_brake, bemf_cmp, ext_sync, fb_ext_sel, pole4_sel;
    logic [2:0] phase_dly, phase_hi, phase_lo, phase_lo_reg;
    logic linear_mode, spin_sense, rev_tick, pump_chg, pump_xfr, noisy;
    logic [1:0] bemf_mux, mux_q;
    logic [7:0] wait_cyc, lf;
    logic sp_q, tc_ok, rv_ok, pl_q, bc_q, ex_q;
    logic [10:0] exp_q [$];
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int np = 0;
    int n_comm = 0;
    int tc, rc, pv, dd, rv_n, step;
    int nc = 0;
    logic ok, h_q;
    logic [10:0] drv, ex;

    // Drive outputs and sensed phase as one word
    assign drv = {phase_hi, phase_lo, phase_lo_reg, bemf_mux};

    scs_sequencer #(.CW(CW), .BRAKE_CYC(BRK)) scs_sequencer_inst (
        .clk(clk), .rst(rst), .run_brake(run_brake), .bemf_cmp(bemf_cmp),
        .ext_sync(ext_sync), .fb_ext_sel(fb_ext_sel), .phase_dly(phase_dly),
        .pole4_sel(pole4_sel), .linear_mode(linear_mode),
        .phase_hi(phase_hi), .phase_lo(phase_lo),
        .phase_lo_reg(phase_lo_reg), .bemf_mux(bemf_mux),
        .spin_sense(spin_sense), .rev_tick(rev_tick),
        .pump_chg(pump_chg), .pump_xfr(pump_xfr));

    scs_motor_model scs_motor_model_inst (
        .clk(clk), .phase_hi(phase_hi), .bemf_mux(bemf_mux),
        .wait_cyc(wait_cyc), .noisy(noisy), .use_ext(fb_ext_sel),
        .bemf_cmp(bemf_cmp), .ext_sync(ext_sync));

    // Clock at 125 MHz
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // Expected drive outputs and sensed phase of one state
    function automatic logic [10:0] ent(input int s);
        return {HI[s], linear_mode ? 3'h0 : LO[s],
                linear_mode ? LO[s] : 3'h0, SN[s]};
    endfunction : ent

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic rst_check;
        check({phase_hi, phase_lo, phase_lo_reg, bemf_mux, spin_sense,
               rev_tick, pump_chg, pump_xfr}, 16'h0020);
    endtask : rst_check

    // Run for n commutations, then coast and brake
    task automatic segment(input int n);
        int k;
        for (k = 1; k <= n; k++)
            exp_q.push_back(ent((step + k) % 6));
        run_brake = 1'b1;
        tick(6);
        check(drv, ent(step));
        k = n_comm + n;
        for (int i = 0; i < n * 400 && n_comm < k; i++)
            tick(1);
        if (n_comm < k)
        begin
            miscompares++;
            end_of_test();
        end
        step = (step + n) % 6;
        run_brake = 1'b0;
        tick(6);
        check({phase_hi, phase_lo, phase_lo_reg}, 16'h0);
        tick(BRK - 4);
        check(phase_lo, 3'h0);
        tick(8);
        check({phase_hi, phase_lo}, 6'h07);
        lf = lfsr(lf);
        wait_cyc = 8'h46 + {3'h0, lf[4:0]};
        lf = lfsr(lf);
    endtask : segment

    // Main sequence
    initial
    begin
        rst = 1'b1;
        run_brake = 1'b0;
        fb_ext_sel = 1'b0;
        pole4_sel = 1'b0;
        linear_mode = 1'b0;
        phase_dly = 3'h0;
        noisy = 1'b0;
        wait_cyc = 8'h50;
        lf = 8'h1F;
        step = 0;
        tick(4);
        rst_check();
        rst = 1'b0;
        tick(300);
        check(spin_sense, 1'b0);
        segment(30);
        linear_mode = 1'b1;
        noisy = 1'b1;
        phase_dly = lf[2:0];
        segment(30);
        linear_mode = 1'b0;
        pole4_sel = 1'b1;
        fb_ext_sel = 1'b1;
        segment(30);
        check(np > 100 && nc > 100, 1'b1);
        rst = 1'b1;
        tick(2);
        rst_check();
        end_of_test();
    end

    // Watcher: each commutation takes the oldest queued state
    always @(posedge clk)
    begin
        #2;
        cyc++;
        np += pump_xfr;
        nc += pump_chg;
        check(pump_chg & pump_xfr, 1'b0);
        if (rst)
        begin
            mux_q = 2'h2;
            sp_q = 1'b0;
            pv = 255;
            tc_ok = 1'b0;
            rv_ok = 1'b0;
            rc = 0;
        end
        else
        begin
            if (!tc_ok && (bemf_cmp !== bc_q || (ext_sync && !ex_q)))
            begin
                tc = cyc;
                tc_ok = 1'b1;
            end
            if (bemf_mux !== mux_q)
            begin
                n_comm++;
                rv_n++;
                ex = exp_q.size() > 0 ? exp_q.pop_front() : 11'h7FF;
                check(drv, ex);
                check(spin_sense, !sp_q);
                dd = pv / 2 - phase_dly * (pv / 16);
                ok = tc_ok && cyc - tc >= dd + 3 && cyc - tc <= dd + 9;
                check(ok, 1'b1);
                // Interval counts only cycles spent running, capped
                pv = rc > 255 ? 255 : rc;
                rc = 0;
                sp_q = spin_sense;
                tc_ok = 1'b0;
                mux_q = bemf_mux;
            end
            else if (h_q)
                rc++;
            if (pole4_sel !== pl_q)
                rv_ok = 1'b0;
            if (rev_tick === 1'b1)
            begin
                if (rv_ok)
                    check(16'(rv_n), pole4_sel ? 16'h0C : 16'h18);
                rv_ok = 1'b1;
                rv_n = 0;
            end
        end
        bc_q = bemf_cmp;
        ex_q = ext_sync;
        pl_q = pole4_sel;
        h_q = phase_hi !== 3'h0;
    end
endmodule : tb_scs_sequencer
`default_nettype wire
